// ### bench/gco_load_model.sv
// gco_load_model: load on the carrier pin plus a free-running oscillator.
// assumes the pin is a registered level on aclk.
`timescale 1ns/1ps
`default_nettype none
module gco_load_model #(
  parameter int XHALF = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic carrier_out_pin,
  output logic xin,
  output logic [15:0] n_rise,
  output logic [15:0] hi_len
);
  logic [7:0] div_r = 8'h00;
  logic [15:0] run_r;
  logic pin_q;
  logic xin_r = 1'b0;
  assign xin = xin_r;
  // ==========================================================
  // oscillator and pin monitor
  always @(posedge aclk) begin
    if (div_r == 8'(XHALF - 1)) begin
      div_r <= 8'h00;
      xin_r <= !xin_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
    pin_q <= carrier_out_pin;
    if (!aresetn) begin
      n_rise <= 16'h0000;
      hi_len <= 16'h0000;
      run_r <= 16'h0000;
    end else begin
      if (carrier_out_pin && !pin_q) n_rise <= n_rise + 16'h0001;
      if (carrier_out_pin) begin
        run_r <= run_r + 16'h0001;
      end else if (pin_q) begin
        hi_len <= run_r;
        run_r <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// testbench: register-level tests of the gated carrier output block.
// assumes gco_pkg is compiled first and the load model drives xin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gco_pkg::*;
  localparam int XP = 8;
  localparam int LO = 1;
  localparam int HI = 2;
  localparam int CP = (LO + HI + 2) * XP;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic xin, awready, wready, bvalid, arready, rvalid, pin, irq;
  logic [GCO_AW-1:0] awaddr = '0;
  logic [GCO_AW-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp;
  logic [15:0] n_rise, hi_len, e0;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, t0, t1;
  logic [GCO_AW-1:0] ra [7] = '{GCO_CARRIER_CTRL, GCO_CARRIER_RELOAD,
    GCO_INTERVAL_CTRL, GCO_INTERVAL_RELOAD, GCO_GATE_CTRL, GCO_STATUS,
    GCO_IRQ_MASK};
  logic [31:0] rv [7] = '{0, 0, 0, 0, 0, 32'h0000_0002, 0};
  always #5 aclk = ~aclk;
  gco_top #(.CW(8), .IW(8)) uut (.aclk(aclk), .aresetn(aresetn),
    .xin(xin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .carrier_out_pin(pin), .irq(irq));
  gco_load_model #(.XHALF(XP / 2)) load (.aclk(aclk), .aresetn(aresetn),
    .carrier_out_pin(pin), .xin(xin), .n_rise(n_rise), .hi_len(hi_len));
  // ==========================================================
  // tasks
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [GCO_AW-1:0] a, input logic [31:0] d,
    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [GCO_AW-1:0] a, output logic [31:0] d,
    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic rc(input logic [GCO_AW-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    rdr(a, d, GCO_RESP_OKAY);
    chk(d, e);
  endtask
  task automatic wait_irq(output int t);
    while (irq !== 1'b1) @(posedge aclk);
    t = cyc;
  endtask
  // ==========================================================
  // watchdog
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc(ra[i], rv[i]);
    rdr(6'h24, rd, GCO_RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    wr(6'h24, 32'h0000_0001, GCO_RESP_SLVERR);
    $display("test reset done");
    wr(GCO_GATE_CTRL, 32'h0000_0001, GCO_RESP_OKAY);
    wr(GCO_CARRIER_RELOAD, 32'(HI * 256 + LO), GCO_RESP_OKAY);
    wr(GCO_INTERVAL_COUNT, 32'h0000_0002, GCO_RESP_OKAY);
    rc(GCO_INTERVAL_COUNT, 32'h0000_0002);
    wr(GCO_INTERVAL_RELOAD, 32'h0000_0002, GCO_RESP_OKAY);
    wr(GCO_IRQ_MASK, 32'h0000_0001, GCO_RESP_OKAY);
    wr(GCO_INTERVAL_CTRL, 32'h0000_0001, GCO_RESP_OKAY);
    wr(GCO_CARRIER_CTRL, 32'h0000_0001, GCO_RESP_OKAY);
    rc(GCO_STATUS, 32'h0000_0006);
    while (hi_len === 16'h0000) @(posedge aclk);
    chk(32'(hi_len), 32'((HI + 1) * XP));
    $display("test start done");
    wait_irq(t0);
    rc(GCO_SKIP_TEST, 32'h0000_0001);
    rc(GCO_SKIP_TEST, 32'h0000_0000);
    e0 = n_rise;
    wait_irq(t1);
    chk(32'(t1 - t0), 32'(3 * CP));
    chk(32'(n_rise - e0), 32'h0000_0000);
    e0 = n_rise;
    wr(GCO_IRQ_MASK, 32'h0000_0000, GCO_RESP_OKAY);
    chk(32'(irq), 32'h0000_0000);
    rc(GCO_STATUS, 32'h0000_0007);
    wr(GCO_STATUS, 32'h0000_0001, GCO_RESP_OKAY);
    rc(GCO_STATUS, 32'h0000_0006);
    wr(GCO_IRQ_MASK, 32'h0000_0001, GCO_RESP_OKAY);
    repeat (CP) @(posedge aclk);
    wr(GCO_INTERVAL_RELOAD, 32'h0000_0000, GCO_RESP_OKAY);
    t0 = t1;
    wait_irq(t1);
    chk(32'(t1 - t0), 32'(3 * CP));
    chk(32'(n_rise - e0), 32'h0000_0003);
    rc(GCO_SKIP_TEST, 32'h0000_0001);
    t0 = t1;
    wait_irq(t1);
    chk(32'(t1 - t0), 32'(CP));
    $display("test intervals done");
    wr(GCO_CARRIER_CTRL, 32'h0000_0000, GCO_RESP_OKAY);
    rc(GCO_STATUS, 32'h0000_0003);
    chk(32'(pin), 32'h0000_0000);
    repeat (CP) @(posedge aclk);
    wr(GCO_INTERVAL_CTRL, 32'h0000_0000, GCO_RESP_OKAY);
    wr(GCO_GATE_CTRL, 32'h0000_0000, GCO_RESP_OKAY);
    rc(GCO_SKIP_TEST, 32'h0000_0001);
    e0 = n_rise;
    wr(GCO_CARRIER_CTRL, 32'h0000_0001, GCO_RESP_OKAY);
    repeat (3 * CP) @(posedge aclk);
    chk(32'(n_rise - e0), 32'h0000_0000);
    rc(GCO_STATUS, 32'h0000_0002);
    $display("test shutdown done");
    test_done;
  end
endmodule
`default_nettype wire

// ### pkg/gco_pkg.sv
// gco_pkg: register map, field positions and reset values of the
// gated carrier output block.
// assumes a 32-bit axi4-lite slave with one aligned word per register.
package gco_pkg;
  // ==========================================================
  // bus
  localparam int GCO_AW = 6;
  localparam logic [1:0] GCO_RESP_OKAY = 2'h0;
  localparam logic [1:0] GCO_RESP_SLVERR = 2'h2;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [GCO_AW-1:0] GCO_CARRIER_CTRL = 6'h00;
  localparam logic [GCO_AW-1:0] GCO_CARRIER_RELOAD = 6'h04;
  localparam logic [GCO_AW-1:0] GCO_INTERVAL_CTRL = 6'h08;
  localparam logic [GCO_AW-1:0] GCO_INTERVAL_COUNT = 6'h0C;
  localparam logic [GCO_AW-1:0] GCO_INTERVAL_RELOAD = 6'h10;
  localparam logic [GCO_AW-1:0] GCO_GATE_CTRL = 6'h14;
  localparam logic [GCO_AW-1:0] GCO_STATUS = 6'h18;
  localparam logic [GCO_AW-1:0] GCO_IRQ_MASK = 6'h1C;
  localparam logic [GCO_AW-1:0] GCO_SKIP_TEST = 6'h20;
  // ==========================================================
  // field positions
  localparam int GCO_RUN_BIT = 0;
  localparam int GCO_AUTO_BIT = 0;
  localparam int GCO_CAR_HI_LSB = 8;
  localparam int GCO_ST_FLAG_BIT = 0;
  localparam int GCO_ST_GATE_BIT = 1;
  localparam int GCO_ST_PIN_BIT = 2;
  // ==========================================================
  // reset values
  localparam logic [15:0] GCO_CAR_RELOAD_RST = 16'h0000;
  localparam logic [15:0] GCO_ITV_RELOAD_RST = 16'h0000;
  localparam logic GCO_MASK_RST = 1'b0;
endpackage

// ### pkg/gco_tmr_if.sv
// gco_tmr_if: control and result signals of one reloading down counter.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface gco_tmr_if #(parameter int W = 8);
  logic run;
  logic tick;
  logic load;
  logic [W-1:0] load_val;
  logic [W-1:0] reload_val;
  logic [W-1:0] count;
  logic uf;
  modport timer (input run, tick, load, load_val, reload_val,
    output count, uf);
  modport user (output run, tick, load, load_val, reload_val,
    input count, uf);
endinterface
`default_nettype wire

// ### rtl/gco_timer.sv
// gco_timer: down counter that underflows after reload plus one ticks.
// assumes tick and load come from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module gco_timer #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  gco_tmr_if.timer t
);
  typedef struct packed {
    logic [W-1:0] count;
  } gco_tmr_s;

  gco_tmr_s st_r;
  gco_tmr_s st_nxt;

  if (W < 2 || W > 16) begin : g_chk
    $error("gco_timer: width must be 2 to 16");
  end

  // ==========================================================
  // count
  assign t.uf = t.run && t.tick && !t.load && (st_r.count == '0);
  assign t.count = st_r.count;

  always_comb begin
    st_nxt = st_r;
    if (t.load) begin
      st_nxt.count = t.load_val;
    end else if (t.uf) begin
      st_nxt.count = t.reload_val;
    end else if (t.run && t.tick) begin
      st_nxt.count = st_r.count - W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ### rtl/gco_top.sv
// gco_top: carrier timer, interval timer and automatic gating of the
// carrier pin, with an axi4-lite register slave.
// assumes xin is an asynchronous oscillator pin slower than aclk / 2.
//
// Overview of operation
// - carrier timer counts main oscillator input rising edges
// - start with auto gating enables carrier pin
// - interval end sets flag; skip-test read clears
// - interval lasts reload plus one carrier periods
// - stopping carrier timer disables carrier pin
// - deselecting auto gating disables carrier pin
// - half period lasts reload plus one input clocks
// - auto gating bit selected before timers start
`timescale 1ns/1ps
`default_nettype none
module gco_top #(
  parameter int CW = 8,
  parameter int IW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xin,
  input wire logic [gco_pkg::GCO_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gco_pkg::GCO_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic carrier_out_pin,
  output logic irq
);
  import gco_pkg::*;

  typedef struct packed {
    logic xs1;
    logic xs2;
    logic xs3;
    logic c_run;
    logic [CW-1:0] c_lo;
    logic [CW-1:0] c_hi;
    logic phase;
    logic i_run;
    logic [IW-1:0] i_reload;
    logic auto_sel;
    logic pin_en;
    logic gate_on;
    logic pin;
    logic flag;
    logic mask;
    logic aw_got;
    logic [GCO_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } gco_state_s;

  gco_state_s st_r;
  gco_state_s st_nxt;

  if (CW < 2 || CW > 8 || IW < 2 || IW > 16) begin : g_chk
    $error("gco_top: CW must be 2 to 8, IW 2 to 16");
  end

  gco_tmr_if #(.W(CW)) car ();
  gco_tmr_if #(.W(IW)) itv ();

  gco_timer #(.W(CW)) u_car (.aclk(aclk), .aresetn(aresetn), .t(car));
  gco_timer #(.W(IW)) u_itv (.aclk(aclk), .aresetn(aresetn), .t(itv));

  // ==========================================================
  // register readback
  function automatic logic [31:0] reg_val(input logic [GCO_AW-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      GCO_CARRIER_CTRL: v[GCO_RUN_BIT] = st_r.c_run;
      GCO_CARRIER_RELOAD: begin
        v[CW-1:0] = st_r.c_lo;
        v[GCO_CAR_HI_LSB +: CW] = st_r.c_hi;
      end
      GCO_INTERVAL_CTRL: v[GCO_RUN_BIT] = st_r.i_run;
      GCO_INTERVAL_COUNT: v[IW-1:0] = itv.count;
      GCO_INTERVAL_RELOAD: v[IW-1:0] = st_r.i_reload;
      GCO_GATE_CTRL: v[GCO_AUTO_BIT] = st_r.auto_sel;
      GCO_STATUS: begin
        v[GCO_ST_FLAG_BIT] = st_r.flag;
        v[GCO_ST_GATE_BIT] = st_r.gate_on;
        v[GCO_ST_PIN_BIT] = st_r.pin_en;
      end
      GCO_IRQ_MASK: v[GCO_ST_FLAG_BIT] = st_r.mask;
      GCO_SKIP_TEST: v[GCO_ST_FLAG_BIT] = st_r.flag;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [GCO_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= GCO_SKIP_TEST);
  endfunction

  // ==========================================================
  // timer hookup
  assign car.run = st_r.c_run;
  assign car.tick = st_r.xs2 && !st_r.xs3;
  assign car.load = !st_r.c_run;
  assign car.load_val = st_r.c_lo;
  assign car.reload_val = st_r.phase ? st_r.c_lo : st_r.c_hi;
  assign itv.run = st_r.i_run;
  assign itv.tick = car.uf && st_r.phase;
  assign itv.reload_val = st_r.i_reload;

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  // ==========================================================
  // next state
  logic wr_go;
  logic [31:0] wd;
  logic flag_clr;
  logic c_start;

  assign wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wd = (reg_val(st_r.aw_addr) & ~{{8{st_r.w_strb[3]}},
    {8{st_r.w_strb[2]}}, {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}})
    | (st_r.w_data & {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}},
    {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}});
  assign itv.load = wr_go && (st_r.aw_addr == GCO_INTERVAL_COUNT);
  assign itv.load_val = wd[IW-1:0];

  always_comb begin
    st_nxt = st_r;
    flag_clr = 1'b0;
    st_nxt.xs1 = xin;
    st_nxt.xs2 = st_r.xs1;
    st_nxt.xs3 = st_r.xs2;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(st_r.aw_addr) ? GCO_RESP_OKAY : GCO_RESP_SLVERR;
      case (st_r.aw_addr)
        GCO_CARRIER_CTRL: st_nxt.c_run = wd[GCO_RUN_BIT];
        GCO_CARRIER_RELOAD: begin
          st_nxt.c_lo = wd[CW-1:0];
          st_nxt.c_hi = wd[GCO_CAR_HI_LSB +: CW];
        end
        GCO_INTERVAL_CTRL: st_nxt.i_run = wd[GCO_RUN_BIT];
        GCO_INTERVAL_RELOAD: st_nxt.i_reload = wd[IW-1:0];
        GCO_GATE_CTRL: st_nxt.auto_sel = wd[GCO_AUTO_BIT];
        GCO_STATUS: flag_clr = st_r.w_strb[0] && st_r.w_data[GCO_ST_FLAG_BIT];
        GCO_IRQ_MASK: st_nxt.mask = wd[GCO_ST_FLAG_BIT];
        default: st_nxt.mask = st_r.mask;
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = reg_val(s_axi_araddr);
      st_nxt.rresp = mapped(s_axi_araddr) ? GCO_RESP_OKAY : GCO_RESP_SLVERR;
      if (s_axi_araddr == GCO_SKIP_TEST) begin
        flag_clr = 1'b1;
      end
    end
    st_nxt.flag = (st_r.flag && !flag_clr) || itv.uf;
    // carrier phase and pin enable
    c_start = st_nxt.c_run && !st_r.c_run;
    if (!st_r.c_run) begin
      st_nxt.phase = 1'b0;
    end else if (car.uf) begin
      st_nxt.phase = !st_r.phase;
    end
    if (!st_nxt.c_run || !st_nxt.auto_sel) begin
      st_nxt.pin_en = 1'b0;
    end else if (c_start) begin
      st_nxt.pin_en = 1'b1;
    end
    if (!st_r.i_run) begin
      st_nxt.gate_on = 1'b1;
    end else if (itv.uf && st_r.auto_sel) begin
      st_nxt.gate_on = !st_r.gate_on;
    end
    st_nxt.pin = st_nxt.pin_en && st_nxt.gate_on && st_nxt.phase;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.c_lo <= GCO_CAR_RELOAD_RST[CW-1:0];
      st_r.c_hi <= GCO_CAR_RELOAD_RST[GCO_CAR_HI_LSB +: CW];
      st_r.i_reload <= GCO_ITV_RELOAD_RST[IW-1:0];
      st_r.mask <= GCO_MASK_RST;
      st_r.gate_on <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign carrier_out_pin = st_r.pin;
  assign irq = st_r.flag && st_r.mask;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  carrier_src_a: assert property (
    car.uf |-> st_r.xs2 && !$past(st_r.xs2))
    else $error("carrier underflow without oscillator edge");
  start_enable_a: assert property (
    $rose(st_r.c_run) && st_r.auto_sel |-> st_r.pin_en)
    else $error("carrier start did not enable pin");
  gate_toggle_a: assert property (
    itv.uf && st_r.auto_sel && st_r.i_run |=> st_r.gate_on != $past(st_r.gate_on))
    else $error("gate did not alternate at interval end");
  flag_set_a: assert property (
    itv.uf |=> st_r.flag)
    else $error("interval end did not set flag");
  skip_clear_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == GCO_SKIP_TEST
    && !itv.uf |=> !st_r.flag && s_axi_rvalid)
    else $error("skip test read did not clear flag");
  interval_len_a: assert property (
    itv.uf |=> itv.count == $past(st_r.i_reload))
    else $error("interval reload not taken at underflow");
  stop_off_a: assert property (
    !st_r.c_run |-> !carrier_out_pin && !st_r.pin_en)
    else $error("pin active with carrier stopped");
  auto_off_a: assert property (
    !st_r.auto_sel |-> !st_r.pin_en)
    else $error("pin gated without auto select");
  half_period_a: assert property (
    car.uf |=> car.count == $past(car.reload_val))
    else $error("carrier reload not taken");
  pin_toggle_a: assert property (
    st_r.pin_en && st_r.gate_on && $stable(st_r.gate_on)
    && $stable(st_r.pin_en) && $changed(st_r.phase)
    |-> $changed(carrier_out_pin))
    else $error("pin did not follow carrier");
  pin_hold_a: assert property (
    !st_r.gate_on |-> !carrier_out_pin)
    else $error("pin active in off interval");

  start_c: cover property ($rose(st_r.pin_en));
  gate_c: cover property (st_r.pin_en && $fell(st_r.gate_on));
  irq_c: cover property ($rose(irq));
  skip_c: cover property ($fell(st_r.flag));
endmodule
`default_nettype wire
